// ---- rtl/pmtef_pkg.sv ----
// Constants shared by the top-level event flag logic
package pmtef_pkg;
   // Register offsets on the serial register port
   localparam logic [7:0] A_RESET   = 8'h18;
   localparam logic [7:0] A_FLAGS1  = 8'h19;
   localparam logic [7:0] A_FLAGS2  = 8'h1A;
   // Bit positions in the first flag register
   localparam int B_PG_DROP = 7;
   localparam int B_LINREG  = 6;
   localparam int B_STEPDN  = 5;
   localparam int B_CLKCHG  = 4;
   localparam int B_TSD     = 3;
   localparam int B_TWARN   = 2;
   localparam int B_OVP     = 1;
   localparam int B_MEAS    = 0;
   // Bit positions in the second flag and reset registers
   localparam int B_RSTFLAG = 0;
   localparam int B_SWRST   = 0;
   // Reset values and masks
   localparam logic [7:0] FLAGS_DFLT  = 8'h00;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [7:0] LATCH_MASK1 = 8'h9F;
   // Indices of the synchronised pin inputs
   localparam int I_PG   = 0;
   localparam int I_CLK  = 1;
   localparam int I_TSD  = 2;
   localparam int I_TWRN = 3;
   localparam int I_OVP  = 4;
   localparam int I_UV   = 5;
   localparam int N_SYNC = 6;
   // Reset sequence, Gray coded along its path
   typedef enum logic [1:0]
   {
      ST_RUN   = 2'h0,
      ST_CLEAR = 2'h1,
      ST_OTP   = 2'h3,
      ST_START = 2'h2
   } pmtef_seq_t;
endpackage : pmtef_pkg

// ---- rtl/pmtef_top.sv ----
// Top-level event flags, soft reset sequence and fault shutdown
`timescale 1ns/1ps
module pmtef_top #(
   parameter int N_REG = 4,
   parameter int N_GPO = 2
) (
   input  wire logic               clk_sys,
   input  wire logic               rstn,
   input  wire logic [7:0]         reg_addr,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic [7:0]         reg_wdata,
   output logic      [7:0]         reg_rdata,
   input  wire logic [7:0]         linreg_event_reg,
   input  wire logic [7:0]         stepdown_event_reg,
   input  wire logic               meas_result_stored,
   input  wire logic               power_good_output,
   input  wire logic               ext_clock_present,
   input  wire logic               thermal_shutdown_live,
   input  wire logic               thermal_warning_live,
   input  wire logic               input_overvoltage_live,
   input  wire logic               analog_supply_low,
   input  wire logic [N_REG-1:0]   regulator_enable_req,
   input  wire logic [N_GPO-1:0]   general_output_req,
   input  wire logic               otp_done,
   input  wire logic               startup_done,
   output logic      [N_REG-1:0]   regulator_enable,
   output logic                    general_output_a,
   output logic                    general_output_b,
   output logic                    defaults_load,
   output logic                    otp_read,
   output logic                    startup_go
);
   localparam int NO = N_REG + N_GPO;

   typedef struct packed {
      logic [pmtef_pkg::N_SYNC-1:0] s1;
      logic [pmtef_pkg::N_SYNC-1:0] s2;
      logic [pmtef_pkg::N_SYNC-1:0] s3;
      logic [pmtef_pkg::N_SYNC-1:0] filt;
      logic [7:0]                   flags1;
      logic                         rst_flag;
      pmtef_pkg::pmtef_seq_t        st;
      logic                         dflt;
      logic                         otp;
      logic                         start;
      logic [NO-1:0]                hold;
      logic [NO-1:0]                outs;
      logic [7:0]                   rdata;
   } pmtef_state_t;

   pmtef_state_t                 q_reg;
   pmtef_state_t                 q_next;
   logic [pmtef_pkg::N_SYNC-1:0] sync_in;
   logic [pmtef_pkg::N_SYNC-1:0] agree;
   logic [pmtef_pkg::N_SYNC-1:0] f_new;
   logic [7:0]                   ev;
   logic [7:0]                   clr1;
   logic                         clr2;
   logic                         swr;
   logic                         uv_rise;
   logic                         seq_go;
   logic                         fault;
   logic [NO-1:0]                req;
   logic [NO-1:0]                sd_block;
   logic [7:0]                   rv;

   assign sync_in = {analog_supply_low, input_overvoltage_live, thermal_warning_live,
                     thermal_shutdown_live, ext_clock_present, power_good_output};
   // A change counts only once stages two and three agree
   assign agree   = ~(q_reg.s2 ^ q_reg.s3);
   assign f_new   = (agree & q_reg.s3) | (~agree & q_reg.filt);
   assign uv_rise = f_new[pmtef_pkg::I_UV] & ~q_reg.filt[pmtef_pkg::I_UV];
   assign req     = {general_output_req, regulator_enable_req};
   assign sd_block = {{N_GPO{1'b0}}, {N_REG{q_reg.flags1[pmtef_pkg::B_TSD]}}};

   always_comb
   begin
      ev = pmtef_pkg::BYTE_ZERO;
      ev[pmtef_pkg::B_PG_DROP] = q_reg.filt[pmtef_pkg::I_PG] & ~f_new[pmtef_pkg::I_PG];
      ev[pmtef_pkg::B_CLKCHG]  = q_reg.filt[pmtef_pkg::I_CLK] ^ f_new[pmtef_pkg::I_CLK];
      ev[pmtef_pkg::B_TSD]     = f_new[pmtef_pkg::I_TSD] & ~q_reg.filt[pmtef_pkg::I_TSD];
      ev[pmtef_pkg::B_TWARN]   = f_new[pmtef_pkg::I_TWRN] & ~q_reg.filt[pmtef_pkg::I_TWRN];
      ev[pmtef_pkg::B_OVP]     = f_new[pmtef_pkg::I_OVP] & ~q_reg.filt[pmtef_pkg::I_OVP];
      ev[pmtef_pkg::B_MEAS]    = meas_result_stored;
   end

   // Write decode; reserved and summary bits are simply not stored
   always_comb
   begin
      clr1 = pmtef_pkg::BYTE_ZERO;
      clr2 = 1'b0;
      swr  = 1'b0;
      if (reg_wr && reg_addr == pmtef_pkg::A_FLAGS1)
      begin
         clr1 = reg_wdata;
      end
      else if (reg_wr && reg_addr == pmtef_pkg::A_FLAGS2)
      begin
         clr2 = reg_wdata[pmtef_pkg::B_RSTFLAG];
      end
      else if (reg_wr && reg_addr == pmtef_pkg::A_RESET)
      begin
         swr = reg_wdata[pmtef_pkg::B_SWRST];
      end
   end

   // Read mux; unmapped offsets answer zero
   always_comb
   begin
      rv = pmtef_pkg::BYTE_ZERO;
      if (reg_addr == pmtef_pkg::A_FLAGS1)
      begin
         rv = q_reg.flags1;
         rv[pmtef_pkg::B_LINREG] = |linreg_event_reg;
         rv[pmtef_pkg::B_STEPDN] = |stepdown_event_reg;
      end
      else if (reg_addr == pmtef_pkg::A_FLAGS2)
      begin
         rv[pmtef_pkg::B_RSTFLAG] = q_reg.rst_flag;
      end
      else if (reg_addr == pmtef_pkg::A_RESET)
      begin
         rv[pmtef_pkg::B_SWRST] = (q_reg.st != pmtef_pkg::ST_RUN);
      end
   end

   always_comb
   begin
      q_next      = q_reg;
      q_next.s1   = sync_in;
      q_next.s2   = q_reg.s1;
      q_next.s3   = q_reg.s2;
      q_next.filt = f_new;
      seq_go      = (swr && q_reg.st == pmtef_pkg::ST_RUN) || uv_rise;
      case (q_reg.st)
         pmtef_pkg::ST_RUN:
            if (seq_go)
            begin
               q_next.st = pmtef_pkg::ST_CLEAR;
            end
         pmtef_pkg::ST_CLEAR:
            q_next.st = pmtef_pkg::ST_OTP;
         pmtef_pkg::ST_OTP:
            if (otp_done)
            begin
               q_next.st = pmtef_pkg::ST_START;
            end
         default:
            if (startup_done)
            begin
               q_next.st = pmtef_pkg::ST_RUN;
            end
      endcase
      // Undervoltage restarts the sequence from any step
      if (uv_rise)
      begin
         q_next.st = pmtef_pkg::ST_CLEAR;
      end
      q_next.dflt  = (q_next.st == pmtef_pkg::ST_CLEAR);
      q_next.otp   = (q_next.st == pmtef_pkg::ST_OTP);
      q_next.start = (q_next.st == pmtef_pkg::ST_START);
      // Set beats clear; defaults then new events during the clear step
      if (q_reg.st == pmtef_pkg::ST_CLEAR)
      begin
         q_next.flags1 = pmtef_pkg::FLAGS_DFLT | ev;
      end
      else
      begin
         q_next.flags1 = ((q_reg.flags1 & ~clr1) | ev) & pmtef_pkg::LATCH_MASK1;
      end
      q_next.rst_flag = (q_reg.rst_flag & ~clr2) | (q_reg.st == pmtef_pkg::ST_CLEAR);
      // Held outputs stay off until their request is withdrawn and reissued; regulators also need the shutdown flag cleared first
      fault = ev[pmtef_pkg::B_TSD] | ev[pmtef_pkg::B_OVP] | (q_next.st != pmtef_pkg::ST_RUN);
      q_next.hold = (q_reg.hold & req) | {NO{fault}} | (req & sd_block);
      q_next.outs = req & ~q_next.hold & ~sd_block;
      if (reg_rd)
      begin
         q_next.rdata = rv;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         q_reg <= '0;
      end
      else
      begin
         q_reg <= q_next;
      end
   end

   assign reg_rdata        = q_reg.rdata;
   assign regulator_enable = q_reg.outs[N_REG-1:0];
   assign general_output_a = q_reg.outs[N_REG];
   assign general_output_b = q_reg.outs[N_REG+1];
   assign defaults_load    = q_reg.dflt;
   assign otp_read         = q_reg.otp;
   assign startup_go       = q_reg.start;

   property p_pg_drop;
      @(posedge clk_sys) disable iff (!rstn)
      (ev[pmtef_pkg::B_PG_DROP] && q_reg.st != pmtef_pkg::ST_CLEAR)
      |=> q_reg.flags1[pmtef_pkg::B_PG_DROP];
   endproperty
   a_pg_drop: assert property (p_pg_drop) else $error("power good drop not latched");

   property p_linreg;
      @(posedge clk_sys) disable iff (!rstn)
      (reg_rd && reg_addr == pmtef_pkg::A_FLAGS1)
      |=> reg_rdata[pmtef_pkg::B_LINREG] == (|$past(linreg_event_reg));
   endproperty
   a_linreg: assert property (p_linreg) else $error("linear summary wrong");

   property p_stepdn;
      @(posedge clk_sys) disable iff (!rstn)
      (reg_rd && reg_addr == pmtef_pkg::A_FLAGS1)
      |=> reg_rdata[pmtef_pkg::B_STEPDN] == (|$past(stepdown_event_reg));
   endproperty
   a_stepdn: assert property (p_stepdn) else $error("stepdown summary wrong");

   property p_clkchg;
      @(posedge clk_sys) disable iff (!rstn)
      $changed(q_reg.filt[pmtef_pkg::I_CLK]) |-> q_reg.flags1[pmtef_pkg::B_CLKCHG];
   endproperty
   a_clkchg: assert property (p_clkchg) else $error("clock change not latched");

   property p_tsd;
      @(posedge clk_sys) disable iff (!rstn)
      ev[pmtef_pkg::B_TSD]
      |=> q_reg.outs == '0 ##1 regulator_enable == '0 [*3];
   endproperty
   a_tsd: assert property (p_tsd) else $error("shutdown left outputs on");

   property p_sd_refuse;
      @(posedge clk_sys) disable iff (!rstn)
      q_reg.flags1[pmtef_pkg::B_TSD] |=> regulator_enable == '0;
   endproperty
   a_sd_refuse: assert property (p_sd_refuse) else $error("enable during shutdown");

   property p_twarn_keep;
      @(posedge clk_sys) disable iff (!rstn)
      (q_reg.flags1[pmtef_pkg::B_TWARN] && !clr1[pmtef_pkg::B_TWARN]
       && q_reg.st != pmtef_pkg::ST_CLEAR)
      |=> q_reg.flags1[pmtef_pkg::B_TWARN];
   endproperty
   a_twarn_keep: assert property (p_twarn_keep) else $error("warning flag lost");

   property p_ovp;
      @(posedge clk_sys) disable iff (!rstn)
      ev[pmtef_pkg::B_OVP]
      |=> q_reg.flags1[pmtef_pkg::B_OVP] && !general_output_a && !general_output_b;
   endproperty
   a_ovp: assert property (p_ovp) else $error("overvoltage not handled");

   property p_meas_race;
      @(posedge clk_sys) disable iff (!rstn)
      (meas_result_stored && clr1[pmtef_pkg::B_MEAS]) |=> q_reg.flags1[pmtef_pkg::B_MEAS];
   endproperty
   a_meas_race: assert property (p_meas_race) else $error("event lost to clear");

   property p_swrst;
      @(posedge clk_sys) disable iff (!rstn)
      (swr && q_reg.st == pmtef_pkg::ST_RUN)
      |=> defaults_load ##1 (otp_read && q_reg.rst_flag);
   endproperty
   a_swrst: assert property (p_swrst) else $error("soft reset sequence wrong");

   property p_rst_flag;
      @(posedge clk_sys) disable iff (!rstn)
      (q_reg.st == pmtef_pkg::ST_CLEAR) |=> q_reg.rst_flag;
   endproperty
   a_rst_flag: assert property (p_rst_flag) else $error("reset flag not set");

   property p_meas;
      @(posedge clk_sys) disable iff (!rstn)
      meas_result_stored |=> q_reg.flags1[pmtef_pkg::B_MEAS];
   endproperty
   a_meas: assert property (p_meas) else $error("measure flag not latched");

   // A zero write may not drop any flag already set
   property p_w0_keep;
      @(posedge clk_sys) disable iff (!rstn)
      (reg_wr && reg_addr == pmtef_pkg::A_FLAGS1 && reg_wdata == pmtef_pkg::BYTE_ZERO
       && q_reg.st != pmtef_pkg::ST_CLEAR)
      |=> (q_reg.flags1 & $past(q_reg.flags1)) == $past(q_reg.flags1);
   endproperty
   a_w0_keep: assert property (p_w0_keep) else $error("zero write changed flags");

   property p_seq_off;
      @(posedge clk_sys) disable iff (!rstn)
      (q_reg.st != pmtef_pkg::ST_RUN)
      |=> regulator_enable == '0 && !general_output_a && !general_output_b;
   endproperty
   a_seq_off: assert property (p_seq_off) else $error("output on during reset");
endmodule : pmtef_top

// ---- verification/pmtef_seq_partner.sv ----
// Model of the memory loader and startup logic behind the reset sequence
`timescale 1ns/1ps
module pmtef_seq_partner #(
   parameter int DLY = 10
) (
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic otp_read,
   input  wire logic startup_go,
   output logic      otp_done,
   output logic      startup_done
);
   int cnt;
   // Count restarts after each done, so the two steps never share a count
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt          <= 0;
         otp_done     <= 1'h0;
         startup_done <= 1'h0;
      end
      else
      begin
         if (otp_done || startup_done || !(otp_read || startup_go))
            cnt <= 0;
         else
            cnt <= cnt + 1;
         otp_done     <= otp_read && (cnt >= DLY);
         startup_done <= startup_go && (cnt >= DLY);
      end
   end
endmodule : pmtef_seq_partner

// ---- verification/pmtef_top_tb_top.sv ----
// Register level testbench for the top-level event flags
`timescale 1ns/1ps
module pmtef_top_tb_top;
   logic clk_sys = 1'h0, rstn = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'h0, reg_rd = 1'h0, meas_result_stored = 1'h0;
   logic [7:0] linreg_event_reg = 8'h00, stepdown_event_reg = 8'h00;
   logic power_good_output = 1'h0, ext_clock_present = 1'h0;
   logic thermal_shutdown_live = 1'h0, thermal_warning_live = 1'h0;
   logic input_overvoltage_live = 1'h0, analog_supply_low = 1'h0;
   logic [3:0] regulator_enable_req = 4'h0, regulator_enable;
   logic [1:0] general_output_req = 2'h0;
   logic general_output_a, general_output_b, defaults_load;
   logic otp_read, startup_go, otp_done, startup_done;
   logic [7:0] eb [5] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02};
   int n_mismatch = 0;
   int tests_run = 0;
   always #20 clk_sys = ~clk_sys;
   pmtef_top DUT (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .linreg_event_reg(linreg_event_reg), .stepdown_event_reg(stepdown_event_reg),
      .meas_result_stored(meas_result_stored), .power_good_output(power_good_output),
      .ext_clock_present(ext_clock_present), .thermal_shutdown_live(thermal_shutdown_live),
      .thermal_warning_live(thermal_warning_live), .analog_supply_low(analog_supply_low),
      .input_overvoltage_live(input_overvoltage_live), .otp_done(otp_done),
      .regulator_enable_req(regulator_enable_req), .general_output_req(general_output_req),
      .startup_done(startup_done), .regulator_enable(regulator_enable),
      .general_output_a(general_output_a), .general_output_b(general_output_b),
      .defaults_load(defaults_load), .otp_read(otp_read), .startup_go(startup_go));
   pmtef_seq_partner u_seq (.clk_sys(clk_sys), .rstn(rstn), .otp_read(otp_read),
      .startup_go(startup_go), .otp_done(otp_done), .startup_done(startup_done));
   task automatic report_and_stop();
      $display("TB: %0d compares, %0d mismatches", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic m);
      @(posedge clk_sys);
      reg_addr           <= a;
      reg_wdata          <= v;
      reg_wr             <= 1'h1;
      meas_result_stored <= m;
      @(posedge clk_sys);
      reg_wr             <= 1'h0;
      meas_result_stored <= 1'h0;
      #1;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge clk_sys);
      reg_rd   <= 1'h0;
      @(posedge clk_sys);
      #1;
      chk(reg_rdata, e);
   endtask : rc
   // Pins pass a synchroniser, so each change is given time to land
   task automatic pin(input int k, input logic v);
      @(posedge clk_sys);
      case (k)
         0: power_good_output <= v;
         1: ext_clock_present <= v;
         2: thermal_shutdown_live <= v;
         3: thermal_warning_live <= v;
         4: input_overvoltage_live <= v;
         default: analog_supply_low <= v;
      endcase
      repeat (8) @(posedge clk_sys);
      #1;
   endtask : pin
   // Re-enable after a fault needs the request dropped and raised again
   task automatic tg();
      @(posedge clk_sys);
      regulator_enable_req <= 4'h0;
      general_output_req   <= 2'h0;
      repeat (4) @(posedge clk_sys);
      regulator_enable_req <= 4'hF;
      general_output_req   <= 2'h3;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : tg
   task automatic wait_seq();
      int n;
      logic seen;
      n = 0;
      seen = 1'h0;
      repeat (3) @(posedge clk_sys);
      while ((otp_read | startup_go | defaults_load) !== 1'h0 && n < 300)
      begin
         seen = seen | startup_go;
         @(posedge clk_sys);
         n++;
      end
      if (n >= 300)
      begin
         n_mismatch++;
         report_and_stop();
      end
      chk({7'h0, seen}, 8'h01);
      #1;
   endtask : wait_seq
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rstn <= 1'h1;
      rc(pmtef_pkg::A_FLAGS1, 8'h00);
      rc(pmtef_pkg::A_FLAGS2, 8'h00);
      rc(8'h30, 8'h00);
      $display("TB: test reset done");
      linreg_event_reg <= 8'h10;
      rc(pmtef_pkg::A_FLAGS1, 8'h40);
      stepdown_event_reg <= 8'h01;
      wr(pmtef_pkg::A_FLAGS1, 8'h60, 1'h0);
      rc(pmtef_pkg::A_FLAGS1, 8'h60);
      linreg_event_reg <= 8'h00;
      stepdown_event_reg <= 8'h00;
      rc(pmtef_pkg::A_FLAGS1, 8'h00);
      $display("TB: test summary done");
      for (int k = 0; k < 5; k++)
      begin
         pin(k, 1'h1);
         pin(k, 1'h0);
         wr(pmtef_pkg::A_FLAGS1, 8'h00, 1'h0);
         rc(pmtef_pkg::A_FLAGS1, eb[k]);
         wr(pmtef_pkg::A_FLAGS1, eb[k], 1'h0);
         rc(pmtef_pkg::A_FLAGS1, 8'h00);
      end
      wr(8'h30, 8'hFF, 1'h1);
      rc(pmtef_pkg::A_FLAGS1, 8'h01);
      wr(pmtef_pkg::A_FLAGS1, 8'h01, 1'h1);
      rc(pmtef_pkg::A_FLAGS1, 8'h01);
      wr(pmtef_pkg::A_FLAGS1, 8'h01, 1'h0);
      rc(pmtef_pkg::A_FLAGS1, 8'h00);
      $display("TB: test events done");
      general_output_req <= 2'h3;
      tg();
      for (int k = 2; k < 5; k += 2)
      begin
         chk({regulator_enable, 2'h0, general_output_b, general_output_a}, 8'hF3);
         pin(k, 1'h1);
         chk({regulator_enable, 2'h0, general_output_b, general_output_a}, 8'h00);
         pin(k, 1'h0);
         tg();
         chk({4'h0, regulator_enable}, (k == 2) ? 8'h00 : 8'h0F);
         wr(pmtef_pkg::A_FLAGS1, 8'hFF, 1'h0);
         tg();
         chk({4'h0, regulator_enable}, 8'h0F);
      end
      $display("TB: test faults done");
      pin(3, 1'h1);
      pin(3, 1'h0);
      wr(pmtef_pkg::A_RESET, 8'h01, 1'h0);
      chk({7'h0, defaults_load}, 8'h01);
      rc(pmtef_pkg::A_RESET, 8'h01);
      chk({7'h0, otp_read}, 8'h01);
      chk({4'h0, regulator_enable}, 8'h00);
      wait_seq();
      rc(pmtef_pkg::A_RESET, 8'h00);
      rc(pmtef_pkg::A_FLAGS1, 8'h00);
      rc(pmtef_pkg::A_FLAGS2, 8'h01);
      tg();
      chk({4'h0, regulator_enable}, 8'h0F);
      wr(pmtef_pkg::A_FLAGS2, 8'hFE, 1'h0);
      rc(pmtef_pkg::A_FLAGS2, 8'h01);
      wr(pmtef_pkg::A_FLAGS2, 8'h01, 1'h0);
      rc(pmtef_pkg::A_FLAGS2, 8'h00);
      $display("TB: test soft reset done");
      pin(5, 1'h1);
      chk({6'h0, startup_go, otp_read}, 8'h01);
      wait_seq();
      pin(5, 1'h0);
      rc(pmtef_pkg::A_FLAGS2, 8'h01);
      chk({4'h0, regulator_enable}, 8'h00);
      $display("TB: test undervoltage done");
      report_and_stop();
   end
endmodule : pmtef_top_tb_top
